/* logic/mrre_core.sv */
// Notes on behaviour
// - copy op writes register to accumulator if dest 0, else back; one cycle
// - copy op sets zero flag from moved value, also on write-back
// - interrupt exit loads pc from stack top, sets interrupt enable; two cycles
// - literal exit loads accumulator with immediate, pc from stack; two cycles
// - subroutine exit loads pc from stack top; accumulator, flags untouched
// - rotate left: carry into bit 0, bit 7 out to carry
// - rotate right: carry into bit 7, bit 0 out to carry
// - rotate dest 1 writes back to register, dest 0 to accumulator
// - call pushes address of the next instruction onto the stack top
`default_nettype none
module mrre_core
    import mrre_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // avalon-mm slave
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // core state
    output logic [7:0] acc_o,
    output logic [10:0] pc_o,
    output logic carry_o,
    output logic zero_o,
    output logic global_interrupt_enable_o
);

    function automatic logic is_return(input mrre_op_t op);
        is_return = (op == INTERRUPT_EXIT_OP) ||
                    (op == EXIT_WITH_LITERAL_OP) ||
                    (op == SUBROUTINE_EXIT_OP);
    endfunction : is_return

    function automatic logic is_rotate(input mrre_op_t op);
        is_rotate = (op == ROTATE_LEFT_CARRY_OP) ||
                    (op == ROTATE_RIGHT_CARRY_OP);
    endfunction : is_rotate

    mrre_state_t state_r;
    logic [7:0] acc_r;
    logic [10:0] pc_r;
    logic carry_r;
    logic zero_r;
    logic gie_r;
    logic [3:0] sp_r;
    logic [10:0] stack_r [0:7];
    logic [7:0] rf_r [0:MRRE_RF_DEPTH-1];
    logic [31:0] rdata_r;

    logic start;
    logic wr_go;
    logic exec;
    logic call_go;
    logic sec_ret;
    logic sec_call;
    logic two_cycle;
    logic dest;
    mrre_op_t op;
    logic [6:0] reg_idx;
    logic [7:0] imm;
    logic [7:0] rd_val;
    logic [7:0] rot_res;
    logic [2:0] top_idx;
    logic [10:0] stack_top;
    logic in_rf;
    logic [6:0] rf_bus_idx;

    always_comb begin
        op = mrre_op_t'(avs_writedata_i[MRRE_OP_LSB +: MRRE_OP_W]);
        dest = avs_writedata_i[MRRE_DEST_BIT];
        reg_idx = avs_writedata_i[MRRE_REG_LSB +: MRRE_REG_W];
        imm = avs_writedata_i[MRRE_IMM_LSB +: MRRE_DW];
        rd_val = rf_r[reg_idx];
        in_rf = avs_address_i[MRRE_RF_SEL_BIT];
        rf_bus_idx = avs_address_i[MRRE_RF_IDX_LSB +: MRRE_REG_W];
        start = (state_r == ST_IDLE) && (avs_read_i || avs_write_i);
        wr_go = start && avs_write_i && avs_byteenable_i[0];
        exec = wr_go && (avs_address_i == MRRE_OFF_CMD);
        call_go = wr_go && (avs_address_i == MRRE_OFF_CALL);
        two_cycle = (exec && is_return(op)) || call_go;
        sec_ret = (state_r == ST_SECOND) && avs_write_i &&
                  (avs_address_i == MRRE_OFF_CMD) && is_return(op);
        sec_call = (state_r == ST_SECOND) && avs_write_i &&
                   (avs_address_i == MRRE_OFF_CALL);
        top_idx = 3'(sp_r - MRRE_SP_STEP);
        stack_top = stack_r[top_idx];
        rot_res = rd_val;
        if (op == ROTATE_LEFT_CARRY_OP) begin
            rot_res = {rd_val[6:0], carry_r};
        end else if (op == ROTATE_RIGHT_CARRY_OP) begin
            rot_res = {carry_r, rd_val[7:1]};
        end
    end

    // bus sequencer: one or two execute cycles, then one answer cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= two_cycle ? ST_SECOND : ST_ACK;
                    end
                end
                ST_SECOND: state_r <= ST_ACK;
                ST_ACK: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            acc_r <= MRRE_ACC_RST;
        end else if (wr_go && avs_address_i == MRRE_OFF_ACC) begin
            acc_r <= avs_writedata_i[MRRE_DW-1:0];
        end else if (exec) begin
            case (op)
                REGISTER_COPY_OP: begin
                    if (!dest) begin
                        acc_r <= rd_val;
                    end
                end
                EXIT_WITH_LITERAL_OP: acc_r <= imm;
                ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP: begin
                    if (!dest) begin
                        acc_r <= rot_res;
                    end
                end
                default: acc_r <= acc_r;
            endcase
        end
    end

    // status flags; returns leave carry and zero alone
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            carry_r <= 1'b0;
            zero_r <= 1'b0;
            gie_r <= 1'b0;
        end else if (wr_go && avs_address_i == MRRE_OFF_STAT) begin
            carry_r <= avs_writedata_i[MRRE_C_BIT];
            zero_r <= avs_writedata_i[MRRE_Z_BIT];
            gie_r <= avs_writedata_i[MRRE_GIE_BIT];
        end else if (exec && op == REGISTER_COPY_OP) begin
            zero_r <= (rd_val == MRRE_ZERO8);
        end else if (exec && is_rotate(op)) begin
            carry_r <= (op == ROTATE_LEFT_CARRY_OP) ? rd_val[7] : rd_val[0];
        end else if (sec_ret && op == INTERRUPT_EXIT_OP) begin
            gie_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pc_r <= MRRE_PC_RST;
        end else if (wr_go && avs_address_i == MRRE_OFF_PC) begin
            pc_r <= avs_writedata_i[MRRE_PC_W-1:0];
        end else if (exec && is_return(op)) begin
            pc_r <= stack_top;
        end else if (sec_call) begin
            pc_r <= avs_writedata_i[MRRE_PC_W-1:0];
        end
    end

    // stack pointer counts used levels; push when full is dropped
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sp_r <= MRRE_SP_RST;
        end else if (call_go && sp_r < MRRE_STK_DEPTH) begin
            sp_r <= sp_r + MRRE_SP_STEP;
        end else if (sec_ret && sp_r != MRRE_SP_RST) begin
            sp_r <= sp_r - MRRE_SP_STEP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (call_go && sp_r < MRRE_STK_DEPTH) begin
            stack_r[sp_r[MRRE_STK_IW-1:0]] <= pc_r + MRRE_PC_STEP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_go && in_rf) begin
            rf_r[rf_bus_idx] <= avs_writedata_i[MRRE_DW-1:0];
        end else if (exec && dest && op == REGISTER_COPY_OP) begin
            rf_r[reg_idx] <= rd_val;
        end else if (exec && dest && is_rotate(op)) begin
            rf_r[reg_idx] <= rot_res;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_r <= MRRE_RD_ZERO;
        end else if (start && avs_read_i) begin
            rdata_r <= MRRE_RD_ZERO;
            if (in_rf) begin
                rdata_r[MRRE_DW-1:0] <= rf_r[rf_bus_idx];
            end else begin
                case (avs_address_i)
                    MRRE_OFF_ACC: rdata_r[MRRE_DW-1:0] <= acc_r;
                    MRRE_OFF_STAT: begin
                        rdata_r[MRRE_C_BIT] <= carry_r;
                        rdata_r[MRRE_Z_BIT] <= zero_r;
                        rdata_r[MRRE_GIE_BIT] <= gie_r;
                    end
                    MRRE_OFF_PC: rdata_r[MRRE_PC_W-1:0] <= pc_r;
                    MRRE_OFF_SP: rdata_r[MRRE_SP_W-1:0] <= sp_r;
                    default: rdata_r <= MRRE_RD_ZERO;
                endcase
            end
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = (state_r != ST_ACK);
    assign acc_o = acc_r;
    assign pc_o = pc_r;
    assign carry_o = carry_r;
    assign zero_o = zero_r;
    assign global_interrupt_enable_o = gie_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    copy_dest_a: assert property (
        exec && op == REGISTER_COPY_OP && !dest
        |=> acc_r == $past(rd_val) && !avs_waitrequest_o)
        else $error("copy to accumulator wrong");
    copy_zero_a: assert property (
        exec && op == REGISTER_COPY_OP
        |=> zero_r == ($past(rd_val) == MRRE_ZERO8) && $stable(carry_r))
        else $error("copy zero flag wrong");
    iret_gie_a: assert property (
        exec && op == INTERRUPT_EXIT_OP
        |=> pc_r == $past(stack_top) ##1 gie_r && !avs_waitrequest_o)
        else $error("interrupt exit wrong");
    lit_exit_a: assert property (
        exec && op == EXIT_WITH_LITERAL_OP
        |=> acc_r == $past(imm) && pc_r == $past(stack_top)
        ##1 $stable(carry_r) && $stable(zero_r) && !avs_waitrequest_o)
        else $error("literal exit wrong");
    sub_exit_a: assert property (
        exec && op == SUBROUTINE_EXIT_OP
        |=> pc_r == $past(stack_top) && $stable(acc_r)
        ##1 $stable(acc_r) && $stable(zero_r) && avs_waitrequest_o == 1'b0)
        else $error("subroutine exit wrong");
    rot_left_a: assert property (
        exec && op == ROTATE_LEFT_CARRY_OP && !dest
        |=> acc_r == {$past(rd_val[6:0]), $past(carry_r)}
        && carry_r == $past(rd_val[7]) && $stable(zero_r))
        else $error("rotate left wrong");
    rot_right_a: assert property (
        exec && op == ROTATE_RIGHT_CARRY_OP && !dest
        |=> acc_r == {$past(carry_r), $past(rd_val[7:1])}
        && carry_r == $past(rd_val[0]) && $stable(zero_r))
        else $error("rotate right wrong");
    rot_back_a: assert property (
        exec && is_rotate(op) && dest |=> $stable(acc_r))
        else $error("rotate write-back touched accumulator");
    call_push_a: assert property (
        call_go && sp_r < MRRE_STK_DEPTH
        |=> stack_top == $past(pc_r) + MRRE_PC_STEP)
        else $error("call push wrong");
    pop_level_a: assert property (
        exec && is_return(op) && sp_r != MRRE_SP_RST
        |=> $stable(sp_r) ##1 sp_r == $past(sp_r, 2) - MRRE_SP_STEP)
        else $error("return pop wrong");

    copy_back_c: cover property (exec && op == REGISTER_COPY_OP && dest);
    iret_c: cover property (exec && op == INTERRUPT_EXIT_OP ##2 gie_r);
    call_ret_c: cover property (call_go ##[1:20] exec && is_return(op));
    rotate_c: cover property (exec && is_rotate(op) && !dest);

endmodule : mrre_core
`default_nettype wire

/* logic/mrre_pkg.sv */
`default_nettype none
package mrre_pkg;
    // byte offsets on the register bus
    localparam logic [9:0] MRRE_OFF_CMD = 10'h000;
    localparam logic [9:0] MRRE_OFF_ACC = 10'h004;
    localparam logic [9:0] MRRE_OFF_STAT = 10'h008;
    localparam logic [9:0] MRRE_OFF_PC = 10'h00C;
    localparam logic [9:0] MRRE_OFF_SP = 10'h010;
    localparam logic [9:0] MRRE_OFF_CALL = 10'h014;
    // address bit that selects the data-memory window
    localparam int unsigned MRRE_RF_SEL_BIT = 9;
    localparam int unsigned MRRE_RF_IDX_LSB = 2;
    // command word fields
    localparam int unsigned MRRE_OP_LSB = 0;
    localparam int unsigned MRRE_OP_W = 3;
    localparam int unsigned MRRE_DEST_BIT = 3;
    localparam int unsigned MRRE_REG_LSB = 4;
    localparam int unsigned MRRE_REG_W = 7;
    localparam int unsigned MRRE_IMM_LSB = 16;
    // status register fields
    localparam int unsigned MRRE_C_BIT = 0;
    localparam int unsigned MRRE_Z_BIT = 1;
    localparam int unsigned MRRE_GIE_BIT = 2;
    // sizes
    localparam int unsigned MRRE_DW = 8;
    localparam int unsigned MRRE_PC_W = 11;
    localparam int unsigned MRRE_SP_W = 4;
    localparam int unsigned MRRE_STK_IW = 3;
    localparam int unsigned MRRE_RF_DEPTH = 128;
    localparam logic [3:0] MRRE_STK_DEPTH = 4'h8;
    // reset values and steps
    localparam logic [7:0] MRRE_ACC_RST = 8'h00;
    localparam logic [7:0] MRRE_ZERO8 = 8'h00;
    localparam logic [10:0] MRRE_PC_RST = 11'h000;
    localparam logic [10:0] MRRE_PC_STEP = 11'h001;
    localparam logic [3:0] MRRE_SP_RST = 4'h0;
    localparam logic [3:0] MRRE_SP_STEP = 4'h1;
    localparam logic [31:0] MRRE_RD_ZERO = 32'h0000_0000;
    // instruction codes in the command word
    typedef enum logic [2:0] {
        REGISTER_COPY_OP = 3'h0,
        INTERRUPT_EXIT_OP = 3'h1,
        EXIT_WITH_LITERAL_OP = 3'h2,
        SUBROUTINE_EXIT_OP = 3'h3,
        ROTATE_LEFT_CARRY_OP = 3'h4,
        ROTATE_RIGHT_CARRY_OP = 3'h5
    } mrre_op_t;
    // bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SECOND = 3'b010,
        ST_ACK = 3'b100
    } mrre_state_t;
endpackage : mrre_pkg
`default_nettype wire

/* bench/test_move_return_rotate_exec.sv */
`default_nettype none
module test_move_return_rotate_exec
    import mrre_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] avs_address_i = 10'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] acc_o;
    logic [10:0] pc_o;
    logic carry_o;
    logic zero_o;
    logic global_interrupt_enable_o;
    logic [31:0] rdata;
    int n_errors = 0;
    int num_checks = 0;
    int lat;

    always #5 clk_i = ~clk_i;

    mrre_core dut (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .acc_o(acc_o),
        .pc_o(pc_o),
        .carry_o(carry_o),
        .zero_o(zero_o),
        .global_interrupt_enable_o(global_interrupt_enable_o)
    );

    task automatic tally_and_finish;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one access, called just after a rising edge; lat counts edges up to
    // and including the answer edge, so it is the execute cycles plus one
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (avs_waitrequest_o !== 1'b0 && lat < 50);
        if (lat >= 50) begin
            n_errors++;
        end
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        // one idle edge keeps the strobes of back-to-back calls apart
        @(posedge clk_i);
    endtask : bus

    task automatic rd(input logic [9:0] a, input logic [31:0] exp,
                      input string what);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rdata, exp);
    endtask : rd

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    function automatic logic [31:0] mk_cmd(input mrre_op_t op,
            input logic dest, input logic [6:0] r, input logic [7:0] imm);
        return {8'h00, imm, 5'h00, r, dest, op};
    endfunction : mk_cmd

    function automatic logic [9:0] rf(input logic [6:0] r);
        return {1'b1, r, 2'b00};
    endfunction : rf

    // issue a command and compare its duration in cycles
    task automatic exec(input logic [31:0] c, input int cyc);
        wr(MRRE_OFF_CMD, c);
        check("cycles", lat, cyc + 1);
    endtask : exec

    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // first request only after the edge that sees reset released
        @(posedge clk_i);
        rd(MRRE_OFF_STAT, 32'h0000_0000, "status rst");
        rd(MRRE_OFF_SP, 32'h0000_0000, "sp rst");
        // copy to accumulator, zero value
        wr(MRRE_OFF_ACC, 32'h0000_00aa);
        wr(rf(7'h05), 32'h0000_0000);
        exec(mk_cmd(REGISTER_COPY_OP, 1'b0, 7'h05, 8'h00), 1);
        rd(MRRE_OFF_ACC, 32'h0000_0000, "acc copy");
        rd(MRRE_OFF_STAT, 32'h0000_0002, "z copy");
        // copy back to register: accumulator kept, zero flag cleared
        wr(rf(7'h06), 32'h0000_0080);
        exec(mk_cmd(REGISTER_COPY_OP, 1'b1, 7'h06, 8'h00), 1);
        check("acc kept", acc_o, 32'h0000_0000);
        check("z back", zero_o, 32'h0000_0000);
        rd(rf(7'h06), 32'h0000_0080, "reg back");
        exec(mk_cmd(REGISTER_COPY_OP, 1'b1, 7'h05, 8'h00), 1);
        check("z back0", zero_o, 32'h0000_0001);
        // rotate left in place, zero flag must stay set
        wr(MRRE_OFF_ACC, 32'h0000_0011);
        wr(rf(7'h07), 32'h0000_00a5);
        wr(MRRE_OFF_STAT, 32'h0000_0002);
        exec(mk_cmd(ROTATE_LEFT_CARRY_OP, 1'b1, 7'h07, 8'h00), 1);
        rd(rf(7'h07), 32'h0000_004a, "rl reg");
        rd(MRRE_OFF_STAT, 32'h0000_0003, "rl flags");
        check("rl acc", acc_o, 32'h0000_0011);
        // rotate right into accumulator with carry set
        exec(mk_cmd(ROTATE_RIGHT_CARRY_OP, 1'b0, 7'h07, 8'h00), 1);
        rd(MRRE_OFF_ACC, 32'h0000_00a5, "rr acc");
        check("rr carry", carry_o, 32'h0000_0000);
        rd(rf(7'h07), 32'h0000_004a, "rr reg");
        // nested calls and returns
        wr(MRRE_OFF_PC, 32'h0000_00a0);
        wr(MRRE_OFF_CALL, 32'h0000_0123);
        wr(MRRE_OFF_CALL, 32'h0000_0200);
        rd(MRRE_OFF_SP, 32'h0000_0002, "sp push");
        wr(MRRE_OFF_STAT, 32'h0000_0003);
        exec(mk_cmd(SUBROUTINE_EXIT_OP, 1'b0, 7'h00, 8'h00), 2);
        rd(MRRE_OFF_PC, 32'h0000_0124, "ret pc");
        rd(MRRE_OFF_SP, 32'h0000_0001, "ret sp");
        rd(MRRE_OFF_ACC, 32'h0000_00a5, "ret acc");
        rd(MRRE_OFF_STAT, 32'h0000_0003, "ret flags");
        exec(mk_cmd(EXIT_WITH_LITERAL_OP, 1'b0, 7'h00, 8'h55), 2);
        check("lit acc", acc_o, 32'h0000_0055);
        check("lit pc", pc_o, 32'h0000_00a1);
        rd(MRRE_OFF_SP, 32'h0000_0000, "lit sp");
        rd(MRRE_OFF_STAT, 32'h0000_0003, "lit flags");
        wr(MRRE_OFF_CALL, 32'h0000_0300);
        exec(mk_cmd(INTERRUPT_EXIT_OP, 1'b0, 7'h00, 8'h00), 2);
        check("gie", global_interrupt_enable_o, 32'h0000_0001);
        rd(MRRE_OFF_PC, 32'h0000_00a2, "iret pc");
        rd(MRRE_OFF_STAT, 32'h0000_0007, "iret flags");
        rd(MRRE_OFF_SP, 32'h0000_0000, "iret sp");
        // unmapped and masked accesses
        rd(10'h018, 32'h0000_0000, "unmapped");
        rd(MRRE_OFF_CMD, 32'h0000_0000, "cmd read");
        avs_byteenable_i <= 4'h0;
        wr(MRRE_OFF_ACC, 32'h0000_0077);
        avs_byteenable_i <= 4'hf;
        rd(MRRE_OFF_ACC, 32'h0000_0055, "masked");
        // spare op code: one cycle, no effect
        exec(mk_cmd(mrre_op_t'(3'h6), 1'b0, 7'h00, 8'h00), 1);
        check("spare op acc", acc_o, 32'h0000_0055);
        tally_and_finish();
    end
endmodule : test_move_return_rotate_exec
`default_nettype wire
